// file: common/ptr_addr_pkg.sv
/*
  Constants, operand encodings and carrier structs for the indexed pointer
  address generator. Assumes a single core clock and that the core presents
  one operand evaluation per request strobe.
*/
package ptr_addr_pkg;
  // ==========================================================================
  // Widths
  localparam int PTR_W = 23;
  localparam int IDX_W = 16;
  localparam int NPTR = 8;
  localparam int SEL_W = 3;
  localparam logic [PTR_W-1:0] PTR_RESET = 23'h000000;
  localparam logic [PTR_W-1:0] STEP_ONE = 23'h000001;
  localparam logic [PTR_W-1:0] STEP_TWO = 23'h000002;
  localparam logic [SEL_W-1:0] PTR_ZERO_SEL = 3'h0;

  // ==========================================================================
  // Operands
  typedef enum logic [3:0] {
    OP_PLAIN = 4'b0000,
    OP_POST_INC = 4'b0001,
    OP_POST_DEC = 4'b0010,
    OP_PRE_INC = 4'b0011,
    OP_PRE_DEC = 4'b0100,
    OP_POST_ADD_IDX = 4'b0101,
    OP_POST_SUB_IDX = 4'b0110,
    OP_BASE_IDX = 4'b0111,
    OP_REV_ADD = 4'b1000,
    OP_REV_SUB = 4'b1001
  } operand_e;

  typedef struct packed {
    logic valid;
    operand_e op;
    logic [SEL_W-1:0] sel;
    logic wide;
    logic [IDX_W-1:0] temp_index_zero;
    logic legacy_compat_mode_bit;
    logic addressing_mode_select;
    logic [NPTR-1:0] circ_enable;
    logic [IDX_W-1:0] buffer_start_register;
  } addr_req_s;

  typedef struct packed {
    logic valid;
    logic unsupported;
    logic [PTR_W-1:0] addr;
    logic [SEL_W-1:0] sel;
    logic [PTR_W-1:0] new_ptr;
  } addr_rsp_s;
endpackage : ptr_addr_pkg

// file: rtl/rev_carry_adder.sv
/*
  Reverse-carry adder: carry ripples from the top bit down to bit 0.
  Assumes purely combinational use inside the address generator.
*/
module rev_carry_adder (
  input wire logic [ptr_addr_pkg::PTR_W-1:0] a_in,
  input wire logic [ptr_addr_pkg::PTR_W-1:0] b_in,
  input wire logic sub_in,
  output logic [ptr_addr_pkg::PTR_W-1:0] sum_out
);
  import ptr_addr_pkg::*;
  // ==========================================================================
  // Ripple chain
  logic [PTR_W:0] carry;
  logic [PTR_W-1:0] b_eff;
  assign b_eff = sub_in ? ~b_in : b_in;
  // Subtraction is two's complement with the carry in at the top bit
  assign carry[PTR_W] = sub_in;
  genvar i;
  generate
    for (i = 0; i < PTR_W; i++) begin : g_bit
      assign sum_out[i] = a_in[i] ^ b_eff[i] ^ carry[i+1];
      assign carry[i] = (a_in[i] & b_eff[i]) |
                        (carry[i+1] & (a_in[i] ^ b_eff[i]));
    end
  endgenerate
endmodule : rev_carry_adder

// file: rtl/indexed_pointer_address_gen.sv
/*
  Indexed pointer address generator: holds eight extended pointers, forms
  one address per request and writes back the updated pointer.
  Assumes the core gives at most one request per clock and holds the
  compat, circular and buffer start settings valid with the request.
*/
module indexed_pointer_address_gen (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire ptr_addr_pkg::addr_req_s req_in,
  input wire logic load_in,
  input wire logic [ptr_addr_pkg::SEL_W-1:0] load_sel_in,
  input wire logic [ptr_addr_pkg::PTR_W-1:0] load_val_in,
  output ptr_addr_pkg::addr_rsp_s rsp_out,
  output logic [ptr_addr_pkg::PTR_W-1:0] extended_aux_pointer_zero_out
);
  import ptr_addr_pkg::*;

  // All checks run on the core clock and pause while reset is high
  default clocking cb_core @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  // ==========================================================================
  // Pointer file
  logic [PTR_W-1:0] extended_aux_pointer_n [NPTR];
  addr_rsp_s rsp;

  // ==========================================================================
  // Decode
  wire [PTR_W-1:0] cur_ptr = extended_aux_pointer_n[req_in.sel];
  wire [PTR_W-1:0] temp_ext =
    {{(PTR_W-IDX_W){req_in.temp_index_zero[IDX_W-1]}},
     req_in.temp_index_zero};
  wire [PTR_W-1:0] index_val = req_in.legacy_compat_mode_bit ?
    extended_aux_pointer_n[PTR_ZERO_SEL] : temp_ext;
  wire [PTR_W-1:0] step = req_in.wide ? STEP_TWO : STEP_ONE;
  wire circ = req_in.circ_enable[req_in.sel];
  wire [PTR_W-1:0] base_ofs = circ ?
    {{(PTR_W-IDX_W){1'b0}}, req_in.buffer_start_register} :
    PTR_RESET;
  wire is_rev = (req_in.op == OP_REV_ADD) || (req_in.op == OP_REV_SUB);
  // Control-mode operands are not handled here; flag them and do nothing
  wire dsp_mode = ~req_in.addressing_mode_select;
  wire go = req_in.valid & dsp_mode;

  wire [PTR_W-1:0] inc_ptr = cur_ptr + step;
  wire [PTR_W-1:0] dec_ptr = cur_ptr - step;
  wire [PTR_W-1:0] add_idx = cur_ptr + index_val;
  wire [PTR_W-1:0] sub_idx = cur_ptr - index_val;
  wire [PTR_W-1:0] rev_sum;

  rev_carry_adder u_rev (
    .a_in(cur_ptr),
    .b_in(index_val),
    .sub_in(req_in.op == OP_REV_SUB),
    .sum_out(rev_sum)
  );

  // ==========================================================================
  // Address and update selection
  logic [PTR_W-1:0] pre_addr;
  logic [PTR_W-1:0] next_ptr;
  always_comb begin
    pre_addr = cur_ptr;
    next_ptr = cur_ptr;
    case (req_in.op)
      OP_PLAIN: begin
      end
      OP_POST_INC: next_ptr = inc_ptr;
      OP_POST_DEC: next_ptr = dec_ptr;
      OP_PRE_INC: begin
        pre_addr = inc_ptr;
        next_ptr = inc_ptr;
      end
      OP_PRE_DEC: begin
        pre_addr = dec_ptr;
        next_ptr = dec_ptr;
      end
      OP_POST_ADD_IDX: next_ptr = add_idx;
      OP_POST_SUB_IDX: next_ptr = sub_idx;
      OP_BASE_IDX: pre_addr = cur_ptr + index_val;
      // Circular bit-reverse leaves the pointer unchanged
      OP_REV_ADD, OP_REV_SUB: begin
        next_ptr = circ ? cur_ptr : rev_sum;
      end
      default: begin
      end
    endcase
  end
  // Address uses the value before any post-update
  wire [PTR_W-1:0] next_addr = pre_addr + base_ofs;
  wire writes = go && (next_ptr != cur_ptr);

  // ==========================================================================
  // Registers
  genvar g;
  generate
    for (g = 0; g < NPTR; g++) begin : g_ptr
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          extended_aux_pointer_n[g] <= PTR_RESET;
        end else if (writes && req_in.sel == SEL_W'(g)) begin
          extended_aux_pointer_n[g] <= next_ptr;
        end else if (load_in && load_sel_in == SEL_W'(g)) begin
          extended_aux_pointer_n[g] <= load_val_in;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rsp <= '0;
    end else begin
      rsp.valid <= go;
      rsp.unsupported <= req_in.valid & ~dsp_mode;
      rsp.addr <= go ? next_addr : rsp.addr;
      rsp.sel <= req_in.sel;
      rsp.new_ptr <= next_ptr;
    end
  end
  assign rsp_out = rsp;
  assign extended_aux_pointer_zero_out = extended_aux_pointer_n[PTR_ZERO_SEL];

  // ==========================================================================
  // Checks
  // Mirrored copies model the reverse carry as a plain add, so the checks
  // do not lean on the adder they watch
  logic [PTR_W-1:0] mir_ptr;
  logic [PTR_W-1:0] mir_idx;
  logic [PTR_W-1:0] mir_add;
  logic [PTR_W-1:0] mir_sub;
  logic [PTR_W-1:0] chk_rev_add;
  logic [PTR_W-1:0] chk_rev_sub;
  wire [PTR_W-1:0] chk_start =
    {{(PTR_W-IDX_W){1'b0}}, req_in.buffer_start_register};
  wire [PTR_W-1:0] chk_ofs = circ ? chk_start : PTR_RESET;
  assign mir_add = mir_ptr + mir_idx;
  assign mir_sub = mir_ptr - mir_idx;
  genvar m;
  generate
    for (m = 0; m < PTR_W; m++) begin : g_mirror
      assign mir_ptr[m] = cur_ptr[PTR_W-1-m];
      assign mir_idx[m] = index_val[PTR_W-1-m];
      assign chk_rev_add[m] = mir_add[PTR_W-1-m];
      assign chk_rev_sub[m] = mir_sub[PTR_W-1-m];
    end
  endgenerate

  AST_POSTDEC: assert property (
    go && req_in.op == OP_POST_DEC |=>
    rsp.addr == $past(cur_ptr) + $past(chk_ofs))
    else $error("post-decrement address not old pointer");
  AST_POSTSUB: assert property (
    go && req_in.op == OP_POST_SUB_IDX |=>
    rsp.addr == $past(cur_ptr) + $past(chk_ofs) &&
    rsp.new_ptr == $past(cur_ptr) - $past(index_val))
    else $error("post-subtract by index wrong");
  AST_COMPAT: assert property (
    go && req_in.op == OP_POST_ADD_IDX && req_in.legacy_compat_mode_bit &&
    req_in.sel != PTR_ZERO_SEL |=>
    extended_aux_pointer_n[$past(req_in.sel)] ==
    $past(cur_ptr) + $past(extended_aux_pointer_n[PTR_ZERO_SEL]))
    else $error("compat index not pointer zero");
  AST_TEMP: assert property (
    go && req_in.op == OP_POST_ADD_IDX && !req_in.legacy_compat_mode_bit |=>
    rsp.new_ptr ==
    $past(cur_ptr) + PTR_W'($signed($past(req_in.temp_index_zero))))
    else $error("temp index not sign-extended");
  AST_BASE: assert property (
    go && req_in.op == OP_BASE_IDX && !load_in |=>
    extended_aux_pointer_n[$past(req_in.sel)] == $past(cur_ptr))
    else $error("base-plus-index changed pointer");
  AST_BASE_ADDR: assert property (
    go && req_in.op == OP_BASE_IDX |=>
    rsp.addr == $past(cur_ptr) + $past(index_val) + $past(chk_ofs))
    else $error("base-plus-index address wrong");
  AST_REVADD: assert property (
    go && req_in.op == OP_REV_ADD && !circ |=>
    rsp.new_ptr == $past(chk_rev_add))
    else $error("reverse carry add wrong");
  AST_REVSUB: assert property (
    go && req_in.op == OP_REV_SUB && !circ |=>
    rsp.new_ptr == $past(chk_rev_sub))
    else $error("reverse borrow subtract wrong");
  AST_REV_CIRC: assert property (
    go && is_rev && circ && !load_in |=>
    extended_aux_pointer_n[$past(req_in.sel)] == $past(cur_ptr) &&
    rsp.addr == $past(cur_ptr) + $past(chk_start))
    else $error("circular bit-reverse moved pointer");
  AST_INC: assert property (
    go && req_in.op == OP_POST_INC |=>
    rsp.new_ptr ==
    $past(cur_ptr) + ($past(req_in.wide) ? STEP_TWO : STEP_ONE))
    else $error("increment step wrong");
  AST_DEC: assert property (
    go && req_in.op == OP_PRE_DEC |=>
    rsp.addr == $past(cur_ptr) - ($past(req_in.wide) ? STEP_TWO : STEP_ONE)
    + $past(chk_ofs))
    else $error("decrement step wrong");
  AST_POSTADD: assert property (
    go && req_in.op == OP_POST_ADD_IDX |=>
    rsp.addr == $past(cur_ptr) + $past(chk_ofs) &&
    rsp.new_ptr == $past(cur_ptr) + $past(index_val))
    else $error("post-add ordering wrong");
  AST_LINEAR: assert property (
    go && !circ && req_in.op == OP_PLAIN |=>
    rsp.addr == $past(cur_ptr))
    else $error("linear address got buffer start");
  AST_CIRC: assert property (
    go && circ && req_in.op == OP_PLAIN |=>
    rsp.addr == $past(cur_ptr) + $past(chk_start))
    else $error("circular address missed buffer start");
  AST_MODE: assert property (
    req_in.valid && req_in.addressing_mode_select |=>
    !rsp.valid && rsp.unsupported)
    else $error("control mode operand processed");
  AST_MODE_HOLD: assert property (
    req_in.valid && req_in.addressing_mode_select && !load_in |=>
    extended_aux_pointer_n[$past(req_in.sel)] == $past(cur_ptr))
    else $error("control mode operand moved pointer");
  AST_WRITEBACK: assert property (
    go && req_in.op == OP_POST_INC |=>
    extended_aux_pointer_n[$past(req_in.sel)] ==
    $past(cur_ptr) + ($past(req_in.wide) ? STEP_TWO : STEP_ONE))
    else $error("updated pointer not written back");

  COV_REV: cover property (go && is_rev && !circ);
  COV_CIRC: cover property (go && circ);
  COV_COMPAT: cover property (go && req_in.legacy_compat_mode_bit);
  COV_MODE: cover property (req_in.valid && req_in.addressing_mode_select);
  COV_BASE: cover property (go && req_in.op == OP_BASE_IDX);
endmodule : indexed_pointer_address_gen

// file: testbench/indexed_pointer_address_gen_test.sv
/*
  Self-checking bench for the indexed pointer address generator.
  Assumes the package and the design files are compiled first.
*/
module indexed_pointer_address_gen_test import ptr_addr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef logic [PTR_W-1:0] ptr_t;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic load_in = 1'b0;
  logic [SEL_W-1:0] load_sel_in = '0;
  ptr_t load_val_in = '0;
  addr_req_s req = '0;
  addr_rsp_s rsp_out;
  ptr_t ptr0_out;
  // Reset clears every pointer, so the model starts from zero
  ptr_t model [NPTR] = '{default: '0};
  int n_fail = 0;
  int comparisons = 0;

  indexed_pointer_address_gen dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .req_in(req), .load_in(load_in), .load_sel_in(load_sel_in),
    .load_val_in(load_val_in), .rsp_out(rsp_out),
    .extended_aux_pointer_zero_out(ptr0_out));

  initial begin
    forever #25 mclk_in = ~mclk_in;
  end

  // ==========================================================================
  // Helpers
  task automatic check(string name, ptr_t seen, ptr_t exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // Bit mirror: reverse carry is a plain add in the mirrored domain
  function automatic ptr_t rev(ptr_t x);
    for (int i = 0; i < PTR_W; i++) rev[i] = x[PTR_W-1-i];
  endfunction : rev

  task automatic load(int s, ptr_t v);
    @(posedge mclk_in);
    load_in <= 1'b1;
    load_sel_in <= s[SEL_W-1:0];
    load_val_in <= v;
    @(posedge mclk_in);
    load_in <= 1'b0;
    model[s] = v;
  endtask : load

  task automatic run(operand_e op, int s, bit w, logic [15:0] tidx, bit cm,
                     bit circ, logic [15:0] base_ofs, bit ms = 1'b0);
    ptr_t p, x, pre, np, ofs;
    addr_req_s r;
    p = model[s];
    x = cm ? model[0] : {{7{tidx[15]}}, tidx};
    case (op)
      OP_PRE_INC, OP_POST_INC: np = p + (w ? STEP_TWO : STEP_ONE);
      OP_PRE_DEC, OP_POST_DEC: np = p - (w ? STEP_TWO : STEP_ONE);
      OP_POST_ADD_IDX: np = p + x;
      OP_POST_SUB_IDX: np = p - x;
      OP_REV_ADD: np = rev(rev(p) + rev(x));
      OP_REV_SUB: np = rev(rev(p) - rev(x));
      default: np = p;
    endcase
    pre = (op inside {OP_PRE_INC, OP_PRE_DEC}) ? np : p;
    if (op == OP_BASE_IDX) pre = p + x;
    if (circ && op inside {OP_REV_ADD, OP_REV_SUB}) np = p;
    ofs = circ ? ptr_t'(base_ofs) : '0;
    r = '0;
    r.valid = 1'b1;
    r.op = op;
    r.sel = s[SEL_W-1:0];
    r.wide = w;
    r.temp_index_zero = tidx;
    r.legacy_compat_mode_bit = cm;
    r.addressing_mode_select = ms;
    // Other pointers get the opposite setting to catch a wrong pick
    r.circ_enable = circ ? 8'h01 << s : ~(8'h01 << s);
    r.buffer_start_register = base_ofs;
    @(posedge mclk_in);
    req <= r;
    @(posedge mclk_in);
    req.valid <= 1'b0;
    #1;
    check("valid", ptr_t'(rsp_out.valid), ptr_t'(!ms));
    check("refused", ptr_t'(rsp_out.unsupported), ptr_t'(ms));
    check("pointer select", ptr_t'(rsp_out.sel), ptr_t'(s));
    if (!ms) begin
      check("address", rsp_out.addr, pre + ofs);
      check("new pointer", rsp_out.new_ptr, np);
      model[s] = np;
    end
    check("pointer zero", ptr0_out, model[0]);
  endtask : run

  // ==========================================================================
  // Scenarios
  task automatic t_step();
    load(1, 23'h0000f0);
    for (int w = 0; w < 2; w++) begin
      run(OP_POST_INC, 1, w[0], '0, 0, 0, '0);
      run(OP_PRE_INC, 1, w[0], '0, 0, 1, 16'h0100);
      run(OP_POST_DEC, 1, w[0], '0, 0, 0, '0);
      run(OP_PRE_DEC, 1, w[0], '0, 0, 1, 16'hffff);
    end
    run(OP_PLAIN, 1, 0, '0, 0, 1, 16'h0040);
    run(OP_PLAIN, 1, 0, '0, 0, 0, '0);
  endtask : t_step

  task automatic t_index();
    load(0, 23'h012345);
    load(2, 23'h400000);
    run(OP_POST_SUB_IDX, 2, 0, 16'hfff0, 0, 0, '0);
    run(OP_POST_ADD_IDX, 2, 0, 16'h8000, 0, 0, '0);
    run(OP_POST_ADD_IDX, 2, 0, 16'h0, 1, 1, 16'h0020);
    run(OP_POST_SUB_IDX, 2, 1, 16'h7fff, 1, 0, '0);
    run(OP_BASE_IDX, 2, 0, 16'hff00, 0, 1, 16'h0010);
    run(OP_BASE_IDX, 2, 0, 16'h0, 1, 0, '0);
    run(OP_PLAIN, 2, 0, '0, 0, 0, '0);
  endtask : t_index

  task automatic t_rev();
    load(3, 23'h000000);
    load(0, 23'h100000);
    run(OP_REV_ADD, 3, 0, 16'h0008, 0, 0, '0);
    run(OP_REV_ADD, 3, 0, 16'h0008, 0, 0, '0);
    run(OP_REV_SUB, 3, 0, 16'h0008, 0, 0, '0);
    run(OP_REV_SUB, 3, 0, 16'hfff8, 0, 0, '0);
    run(OP_REV_ADD, 3, 0, 16'h0, 1, 0, '0);
    run(OP_REV_ADD, 3, 0, 16'h0004, 0, 1, 16'h0200);
    run(OP_REV_SUB, 3, 0, 16'h0004, 0, 1, 16'h0200);
    run(OP_PLAIN, 3, 0, '0, 0, 0, '0);
  endtask : t_rev

  task automatic t_mode();
    run(OP_POST_INC, 3, 1, '0, 0, 0, '0, 1);
    run(OP_PLAIN, 3, 0, '0, 0, 0, '0);
  endtask : t_mode

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (8) @(posedge mclk_in);
    check("reset pointer", ptr0_out, '0);
    check("reset address", rsp_out.addr, '0);
    rst_in <= 1'b0;
    t_step();
    t_index();
    t_rev();
    t_mode();
    end_sim();
  end

  // About 72 cycles expected; allow roughly fourteen times that
  initial begin
    #50us;
    n_fail++;
    end_sim();
  end
endmodule : indexed_pointer_address_gen_test
